//--- rtl/iosd_pkg.sv
// Notes on behaviour
// - Low region supports bit set, clear, test at I/O 0x00-0x1F only
// - Bit set/clear changes only the addressed bit
// - Bit instructions reach only I/O 0x00-0x1F
// - Some flags clear on writing one
// - Port instructions reach only I/O 0x00-0x3F
// - Data address equals I/O number plus 0x20
// - Extended region reachable only by load/store
`default_nettype none

package iosd_pkg;

  // ==========================================================
  // Address windows
  localparam logic [7:0] IOSD_BIT_LAST = 8'h1F;
  localparam logic [7:0] IOSD_PORT_LAST = 8'h3F;
  localparam logic [7:0] IOSD_DATA_OFS = 8'h20;
  localparam logic [7:0] IOSD_EXT_FIRST = 8'h60;
  localparam int IOSD_IO_N = 64;
  localparam logic [7:0] IOSD_RST_VAL = 8'h00;

  // Low-region event flag register (write one to clear)
  localparam int IOSD_FLAG_IO = 22;
  localparam logic [7:0] IOSD_FLAG_IO_ADDR = 8'h16;

  // ==========================================================
  // Extended region: stored registers
  localparam int IOSD_EXT_N = 15;
  localparam logic [7:0] IOSD_EXT_ADDR [IOSD_EXT_N] = '{
    8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6B, 8'h6C,
    8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h7A, 8'h7B, 8'h7C};
  // Writable bits; reserved bit positions are zero here
  localparam logic [7:0] IOSD_EXT_RW [IOSD_EXT_N] = '{
    8'h7F, 8'h8F, 8'hEF, 8'hFF, 8'h07, 8'h0F, 8'hFF, 8'h7F,
    8'hFF, 8'h07, 8'h27, 8'h07, 8'hEF, 8'h47, 8'hEF};
  // Status flag bits that clear on a written one
  localparam logic [7:0] IOSD_EXT_W1C [IOSD_EXT_N] = '{
    8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  localparam int IOSD_IDX_WDOG = 0;
  localparam int IOSD_IDX_CONV_A = 12;
  localparam logic [7:0] IOSD_WDOG_FLAG = 8'h80;
  localparam logic [7:0] IOSD_CONV_FLAG = 8'h10;

  // Extended region: read-only conversion result
  localparam logic [7:0] IOSD_CONV_LO_ADDR = 8'h78;
  localparam logic [7:0] IOSD_CONV_HI_ADDR = 8'h79;

  // ==========================================================
  // Access kinds issued by the core
  typedef enum logic [2:0] {
    IOSD_K_PORT_RD = 3'h0,
    IOSD_K_PORT_WR = 3'h1,
    IOSD_K_SET_BIT = 3'h2,
    IOSD_K_CLR_BIT = 3'h3,
    IOSD_K_SKIP_SET = 3'h4,
    IOSD_K_SKIP_CLR = 3'h5,
    IOSD_K_DATA_LD = 3'h6,
    IOSD_K_DATA_ST = 3'h7
  } iosd_kind_t;

  typedef struct packed {
    logic valid;
    iosd_kind_t kind;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] wdata;
  } iosd_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] rdata;
    logic bit_val;
    logic skip;
  } iosd_resp_t;

  typedef struct packed {
    logic legal;
    logic rd;
    logic wr;
    logic test;
    logic skip_on_set;
    logic [7:0] daddr;
    logic [7:0] wmask;
    logic [7:0] wdata;
  } iosd_dec_t;

endpackage : iosd_pkg

`default_nettype wire

//--- rtl/iosd_byte_reg.sv
`default_nettype none

// ==========================================================
// One 8-bit register with writable and write-one-to-clear bits
module iosd_byte_reg #(
  parameter logic [7:0] RW_MASK = 8'hFF,
  parameter logic [7:0] W1C_MASK = 8'h00,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write port
  input wire logic we_in,
  input wire logic [7:0] wmask_in,
  input wire logic [7:0] wdata_in,
  // Hardware flag set
  input wire logic [7:0] hw_set_in,
  // Value
  output logic [7:0] q_out
);

  logic [7:0] wr_bits;
  logic [7:0] clr_bits;
  logic [7:0] q_nxt;

  // Only lanes in the write mask move; reserved lanes never do
  assign wr_bits = we_in ? (wmask_in & RW_MASK) : 8'h00;
  assign clr_bits = we_in ? (wdata_in & wmask_in & W1C_MASK) : 8'h00;

  // Hardware set wins over a same-cycle software clear
  assign q_nxt = (((q_out & ~wr_bits) | (wdata_in & wr_bits)) & ~clr_bits)
                 | (hw_set_in & W1C_MASK);

  // Register update
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_out <= RST_VAL;
    end else begin
      q_out <= q_nxt;
    end
  end

endmodule : iosd_byte_reg

`default_nettype wire

//--- rtl/iosd_addr_map.sv
`default_nettype none

// ==========================================================
// Maps an access to a data address, lane mask and legality
module iosd_addr_map (
  // Request
  input wire iosd_pkg::iosd_req_t req_in,
  // Decoded access
  output iosd_pkg::iosd_dec_t dec_out
);

  logic [7:0] bit_one;
  logic [7:0] io_daddr;

  assign bit_one = 8'h01 << req_in.bitsel;
  assign io_daddr = 8'(req_in.addr + iosd_pkg::IOSD_DATA_OFS);

  // Decode per access kind
  always_comb begin
    dec_out = '0;
    dec_out.daddr = io_daddr;
    unique case (req_in.kind)
      iosd_pkg::IOSD_K_PORT_RD, iosd_pkg::IOSD_K_PORT_WR: begin
        // Six-bit I/O numbering only; extended region is out of reach
        dec_out.legal = (req_in.addr <= iosd_pkg::IOSD_PORT_LAST);
        dec_out.rd = (req_in.kind == iosd_pkg::IOSD_K_PORT_RD);
        dec_out.wr = (req_in.kind == iosd_pkg::IOSD_K_PORT_WR);
        dec_out.wmask = 8'hFF;
        dec_out.wdata = req_in.wdata;
      end
      iosd_pkg::IOSD_K_SET_BIT, iosd_pkg::IOSD_K_CLR_BIT: begin
        dec_out.legal = (req_in.addr <= iosd_pkg::IOSD_BIT_LAST);
        dec_out.wr = 1'b1;
        // One lane written, so other flags see no write-one
        dec_out.wmask = bit_one;
        dec_out.wdata = (req_in.kind == iosd_pkg::IOSD_K_SET_BIT) ? bit_one : 8'h00;
      end
      iosd_pkg::IOSD_K_SKIP_SET, iosd_pkg::IOSD_K_SKIP_CLR: begin
        dec_out.legal = (req_in.addr <= iosd_pkg::IOSD_BIT_LAST);
        dec_out.rd = 1'b1;
        dec_out.test = 1'b1;
        dec_out.skip_on_set = (req_in.kind == iosd_pkg::IOSD_K_SKIP_SET);
      end
      iosd_pkg::IOSD_K_DATA_LD, iosd_pkg::IOSD_K_DATA_ST: begin
        // Data addresses below the I/O window are not this block's
        dec_out.daddr = req_in.addr;
        dec_out.legal = (req_in.addr >= iosd_pkg::IOSD_DATA_OFS);
        dec_out.rd = (req_in.kind == iosd_pkg::IOSD_K_DATA_LD);
        dec_out.wr = (req_in.kind == iosd_pkg::IOSD_K_DATA_ST);
        dec_out.wmask = 8'hFF;
        dec_out.wdata = req_in.wdata;
      end
    endcase
  end

endmodule : iosd_addr_map

`default_nettype wire

//--- rtl/iosd_io_space.sv
`default_nettype none

// ==========================================================
// I/O register space as seen by the core
module iosd_io_space (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Core access
  input wire iosd_pkg::iosd_req_t req_in,
  output iosd_pkg::iosd_resp_t resp_out,
  // Hardware events and read-only data
  input wire logic [7:0] event_flag_set_in,
  input wire logic wdog_flag_set_in,
  input wire logic conv_done_set_in,
  input wire logic [15:0] conv_result_in,
  // Register contents to peripherals
  output logic [iosd_pkg::IOSD_IO_N-1:0][7:0] io_regs_out,
  output logic [iosd_pkg::IOSD_EXT_N-1:0][7:0] ext_regs_out
);

  // ==========================================================
  // Decode
  iosd_pkg::iosd_dec_t dec;
  logic acc_ok;
  logic low_hit;
  logic [5:0] low_idx;
  logic [iosd_pkg::IOSD_EXT_N-1:0] ext_hit;
  logic conv_lo_hit;
  logic conv_hi_hit;
  logic [7:0] rd_val;
  iosd_pkg::iosd_resp_t resp_r;

  iosd_addr_map u_map (
    .req_in(req_in),
    .dec_out(dec)
  );

  assign acc_ok = req_in.valid && dec.legal;

  // I/O numbers 0x00-0x3F live at data addresses 0x20-0x5F
  assign low_hit = acc_ok && (dec.daddr < iosd_pkg::IOSD_EXT_FIRST);
  assign low_idx = 6'(dec.daddr - iosd_pkg::IOSD_DATA_OFS);
  assign conv_lo_hit = acc_ok && (dec.daddr == iosd_pkg::IOSD_CONV_LO_ADDR);
  assign conv_hi_hit = acc_ok && (dec.daddr == iosd_pkg::IOSD_CONV_HI_ADDR);

  // ==========================================================
  // Low region: general registers plus one event flag register
  genvar gi;
  generate
    for (gi = 0; gi < iosd_pkg::IOSD_IO_N; gi++) begin : g_low
      localparam logic [7:0] RW = (gi == iosd_pkg::IOSD_FLAG_IO) ? 8'h00 : 8'hFF;
      localparam logic [7:0] W1C = (gi == iosd_pkg::IOSD_FLAG_IO) ? 8'hFF : 8'h00;
      logic hw_sel;
      assign hw_sel = (gi == iosd_pkg::IOSD_FLAG_IO);
      iosd_byte_reg #(
        .RW_MASK(RW),
        .W1C_MASK(W1C),
        .RST_VAL(iosd_pkg::IOSD_RST_VAL)
      ) u_reg (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .we_in(low_hit && dec.wr && (low_idx == 6'(gi))),
        .wmask_in(dec.wmask),
        .wdata_in(dec.wdata),
        .hw_set_in(hw_sel ? event_flag_set_in : 8'h00),
        .q_out(io_regs_out[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Extended region: reachable only through data loads and stores
  generate
    for (gi = 0; gi < iosd_pkg::IOSD_EXT_N; gi++) begin : g_ext
      logic [7:0] hw_set;
      assign ext_hit[gi] = acc_ok && (dec.daddr == iosd_pkg::IOSD_EXT_ADDR[gi]);
      assign hw_set = (gi == iosd_pkg::IOSD_IDX_WDOG) ?
                        (wdog_flag_set_in ? iosd_pkg::IOSD_WDOG_FLAG : 8'h00) :
                      (gi == iosd_pkg::IOSD_IDX_CONV_A) ?
                        (conv_done_set_in ? iosd_pkg::IOSD_CONV_FLAG : 8'h00) : 8'h00;
      iosd_byte_reg #(
        .RW_MASK(iosd_pkg::IOSD_EXT_RW[gi]),
        .W1C_MASK(iosd_pkg::IOSD_EXT_W1C[gi]),
        .RST_VAL(iosd_pkg::IOSD_RST_VAL)
      ) u_reg (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .we_in(ext_hit[gi] && dec.wr),
        .wmask_in(dec.wmask),
        .wdata_in(dec.wdata),
        .hw_set_in(hw_set),
        .q_out(ext_regs_out[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Read mux: unmapped extended addresses fall through to zero
  always_comb begin
    rd_val = 8'h00;
    if (low_hit) begin
      rd_val = io_regs_out[low_idx];
    end
    for (int i = 0; i < iosd_pkg::IOSD_EXT_N; i++) begin
      if (ext_hit[i]) begin
        // Reserved bit positions always read back as zero
        rd_val = ext_regs_out[i] & (iosd_pkg::IOSD_EXT_RW[i] | iosd_pkg::IOSD_EXT_W1C[i]);
      end
    end
    if (conv_lo_hit) begin
      rd_val = conv_result_in[7:0];
    end
    if (conv_hi_hit) begin
      rd_val = conv_result_in[15:8];
    end
  end

  // ==========================================================
  // Response: one cycle after the request is taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      resp_r <= '0;
    end else begin
      resp_r.valid <= req_in.valid;
      resp_r.err <= req_in.valid && !dec.legal;
      resp_r.rdata <= (acc_ok && dec.rd) ? rd_val : 8'h00;
      resp_r.bit_val <= acc_ok && dec.rd && rd_val[req_in.bitsel];
      // Skip when the tested bit equals the sense of the instruction
      resp_r.skip <= acc_ok && dec.test && (rd_val[req_in.bitsel] == dec.skip_on_set);
    end
  end

  assign resp_out = resp_r;

endmodule : iosd_io_space

`default_nettype wire

//--- bench/iosd_io_space_monitor.sv
`default_nettype none

// ==========================================================
// Port-level checks of the I/O space decode
module iosd_io_space_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Core access
  input wire iosd_pkg::iosd_req_t req_in,
  input wire iosd_pkg::iosd_resp_t resp_out,
  // Events and register contents
  input wire logic wdog_flag_set_in,
  input wire logic [15:0] conv_result_in,
  input wire logic [iosd_pkg::IOSD_IO_N-1:0][7:0] io_regs_out,
  input wire logic [iosd_pkg::IOSD_EXT_N-1:0][7:0] ext_regs_out
);
  timeunit 1ns;
  timeprecision 1ns;
  iosd_pkg::iosd_req_t req_r;
  logic [7:0] old_r;
  // Keep the last request and its old register, so bit ops are judged after the edge
  always_ff @(posedge clk_in) begin
    req_r <= rst_in ? '0 : req_in;
    old_r <= io_regs_out[req_in.addr[5:0]];
  end
  // Event flags at 0x16 move on their own, so they are left out here
  wire logic low_r = req_r.valid && req_r.addr <= 8'h1F && req_r.addr != 8'h16;
  wire logic [7:0] bit_r = 8'h01 << req_r.bitsel;
  wire logic [7:0] now_r = io_regs_out[req_r.addr[5:0]];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Request of one kind group (port, bit, skip, data) taken at this edge
  sequence s_take(logic [1:0] grp);
    req_in.valid && req_in.kind[2:1] == grp;
  endsequence

  a_bit_write: assert property (low_r && req_r.kind[2:1] == 2'h1 |->
    now_r == (req_r.kind[0] ? old_r & ~bit_r : old_r | bit_r)) else $error("bit op wrong");
  a_skip_bit: assert property (low_r && req_r.kind[2:1] == 2'h2 |->
    resp_out.skip == (old_r[req_r.bitsel] ^ req_r.kind[0])) else $error("skip wrong");
  a_bit_range: assert property (s_take(2'h1) ##0 req_in.addr > 8'h1F |=>
    resp_out.err && resp_out.rdata == 8'h00) else $error("bit op not refused");
  a_port_range: assert property (s_take(2'h0) ##0 req_in.addr > 8'h3F |=>
    resp_out.err) else $error("port access not refused");
  a_data_low: assert property (s_take(2'h3) ##0 req_in.addr < 8'h20 |=>
    resp_out.err) else $error("low data access not refused");
  a_data_offset: assert property (req_r.valid && req_r.kind == 3'h7
    && req_r.addr inside {[8'h20:8'h5F]} && req_r.addr != 8'h36 |->
    io_regs_out[6'(req_r.addr - 8'h20)] == req_r.wdata) else $error("store missed");
  a_flag_clear: assert property (s_take(2'h3) ##0 req_in.kind[0]
    && req_in.addr == 8'h60 && req_in.wdata[7] && !wdog_flag_set_in |=>
    !ext_regs_out[0][7]) else $error("flag not cleared");
  a_flag_keep: assert property (s_take(2'h3) ##0 req_in.kind[0]
    && req_in.addr == 8'h60 && !req_in.wdata[7] |=>
    ext_regs_out[0][7] || !$past(ext_regs_out[0][7])) else $error("flag lost");
  a_reserved_zero: assert property (s_take(2'h3) ##0 !req_in.kind[0]
    && req_in.addr > 8'h7C |=> !resp_out.err && resp_out.rdata == 8'h00)
    else $error("reserved not zero");
  a_conv_read: assert property (s_take(2'h3) ##0 !req_in.kind[0]
    && req_in.addr == 8'h79 |=> resp_out.rdata == $past(conv_result_in[15:8]))
    else $error("result byte wrong");
  // Every taken access is answered on the next edge, and only then
  a_resp_valid: assert property (req_in.valid |=> resp_out.valid)
    else $error("access not answered");
  a_resp_idle: assert property (!req_in.valid |=> !resp_out.valid)
    else $error("answer without access");
endmodule : iosd_io_space_monitor

bind iosd_io_space iosd_io_space_monitor u_mon (
  .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .resp_out(resp_out),
  .wdog_flag_set_in(wdog_flag_set_in), .conv_result_in(conv_result_in),
  .io_regs_out(io_regs_out), .ext_regs_out(ext_regs_out));

`default_nettype wire

//--- bench/iosd_core_model.sv
`default_nettype none

// ==========================================================
// Processor core: one access per call, one idle cycle between
module iosd_core_model (
  // Clock
  input wire logic clk_in,
  // Access to the I/O space
  output var iosd_pkg::iosd_req_t req_out,
  input wire iosd_pkg::iosd_resp_t resp_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_out = '0;
  // Hold the request through the taking edge; the answer is read at the falling edge after it.
  // Callers may set reserved bits and reach reserved places, as the extended map and reserved tests do
  task automatic access(input iosd_pkg::iosd_kind_t k, input logic [7:0] a,
    input logic [2:0] b, input logic [7:0] d, output iosd_pkg::iosd_resp_t r);
    @(negedge clk_in);
    req_out = '{valid: 1'b1, kind: k, addr: a, bitsel: b, wdata: d};
    @(posedge clk_in);
    @(negedge clk_in);
    r = resp_in;
    // Released lines carry junk, so no stale value looks valid
    req_out.valid = 1'b0;
    req_out.addr = ~a;
    req_out.wdata = ~d;
  endtask : access
endmodule : iosd_core_model

`default_nettype wire

//--- bench/iosd_io_space_tb.sv
`default_nettype none

// ==========================================================
// Self-checking bench for the I/O space
module iosd_io_space_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] ev_set = 8'h00;
  logic wdog_set = 1'b0;
  logic conv_set = 1'b0;
  logic [15:0] conv_res = 16'h0000;
  iosd_pkg::iosd_req_t req;
  iosd_pkg::iosd_resp_t resp;
  iosd_pkg::iosd_resp_t r;
  int err_count = 0;
  int compares = 0;

  // System clock, 40 ns period
  always #20 clk_in = ~clk_in;

  iosd_io_space u_dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .resp_out(resp),
    .event_flag_set_in(ev_set), .wdog_flag_set_in(wdog_set), .conv_done_set_in(conv_set),
    .conv_result_in(conv_res), .io_regs_out(), .ext_regs_out());
  iosd_core_model u_core (.clk_in(clk_in), .req_out(req), .resp_in(resp));

  // ==========================================================
  // Compare, access and event tasks
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input iosd_pkg::iosd_kind_t k, input logic [7:0] a, input logic [2:0] b,
    input logic [7:0] d);
    u_core.access(k, a, b, d, r);
  endtask : wr
  // Access, then compare error flag and read data together
  task automatic ex(input iosd_pkg::iosd_kind_t k, input logic [7:0] a, input logic [8:0] e);
    u_core.access(k, a, 3'h0, 8'h00, r);
    chk({r.err, r.rdata}, e);
  endtask : ex
  task automatic pulse();
    @(negedge clk_in);
    ev_set = 8'h81;
    wdog_set = 1'b1;
    conv_set = 1'b1;
    @(negedge clk_in);
    ev_set = 8'h00;
    wdog_set = 1'b0;
    conv_set = 1'b0;
  endtask : pulse
  task automatic close_out();
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Whole run takes a few hundred cycles; a hang is cut short well beyond that
  initial begin
    #100000;
    err_count++;
    close_out();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < iosd_pkg::IOSD_EXT_N; i++) begin
      ex(iosd_pkg::IOSD_K_DATA_LD, iosd_pkg::IOSD_EXT_ADDR[i], 9'h000);
      wr(iosd_pkg::IOSD_K_DATA_ST, iosd_pkg::IOSD_EXT_ADDR[i], 3'h0, 8'hFF);
      ex(iosd_pkg::IOSD_K_DATA_LD, iosd_pkg::IOSD_EXT_ADDR[i], {1'b0, iosd_pkg::IOSD_EXT_RW[i]});
      wr(iosd_pkg::IOSD_K_DATA_ST, iosd_pkg::IOSD_EXT_ADDR[i], 3'h0, 8'h00);
    end
    $display("test extended map done");
    wr(iosd_pkg::IOSD_K_PORT_WR, 8'h05, 3'h0, 8'hA5);
    wr(iosd_pkg::IOSD_K_SET_BIT, 8'h05, 3'h3, 8'h00);
    wr(iosd_pkg::IOSD_K_CLR_BIT, 8'h05, 3'h0, 8'h00);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h05, 9'h0AC);
    wr(iosd_pkg::IOSD_K_SKIP_SET, 8'h05, 3'h3, 8'h00);
    chk({7'h00, r.skip, r.bit_val}, 9'h003);
    wr(iosd_pkg::IOSD_K_SKIP_CLR, 8'h05, 3'h3, 8'h00);
    chk({7'h00, r.skip, r.bit_val}, 9'h001);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h25, 9'h0AC);
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h5F, 3'h0, 8'h3C);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h3F, 9'h03C);
    wr(iosd_pkg::IOSD_K_SET_BIT, 8'h20, 3'h1, 8'h00);
    chk({r.err, r.rdata}, 9'h100);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h20, 9'h000);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h40, 9'h100);
    ex(iosd_pkg::IOSD_K_PORT_WR, 8'h60, 9'h100);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h1F, 9'h100);
    $display("test decode and bit ops done");
    pulse();
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h16, 9'h081);
    wr(iosd_pkg::IOSD_K_SET_BIT, 8'h16, 3'h0, 8'h00);
    wr(iosd_pkg::IOSD_K_CLR_BIT, 8'h16, 3'h7, 8'h00);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h16, 9'h080);
    wr(iosd_pkg::IOSD_K_PORT_WR, 8'h16, 3'h0, 8'h00);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h16, 9'h080);
    wr(iosd_pkg::IOSD_K_PORT_WR, 8'h16, 3'h0, 8'h80);
    ex(iosd_pkg::IOSD_K_PORT_RD, 8'h16, 9'h000);
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h60, 3'h0, 8'h00);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h60, 9'h080);
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h60, 3'h0, 8'h80);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h60, 9'h000);
    // The done flag must have been raised, or the clear below proves nothing
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h7A, 9'h010);
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h7A, 3'h0, 8'h10);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h7A, 9'h000);
    $display("test flags done");
    conv_res = 16'hBEEF;
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h78, 3'h0, 8'h00);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h78, 9'h0EF);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h79, 9'h0BE);
    wr(iosd_pkg::IOSD_K_DATA_ST, 8'h62, 3'h0, 8'hFF);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h62, 9'h000);
    ex(iosd_pkg::IOSD_K_DATA_LD, 8'h7D, 9'h000);
    $display("test reserved and result done");
    close_out();
  end
endmodule : iosd_io_space_tb

`default_nettype wire
